// [logic/cmms_defines.vh]
// Constants for the core memory map and status block
`ifndef CMMS_DEFINES_VH
`define CMMS_DEFINES_VH

// Program space
`define CMMS_PC_W 11
`define CMMS_RESET_VEC 11'h000
`define CMMS_INT_VEC 11'h004
`define CMMS_STACK_DEPTH 6

// Data space
`define CMMS_DADDR_W 8
`define CMMS_SYS_LAST 8'h07
`define CMMS_PERIPH_LAST 8'h7f
`define CMMS_GP_FIRST 8'h80
`define CMMS_GP_WORDS 128

// System register offsets
`define CMMS_OFF_INDIRECT_PORT_A 8'h00
`define CMMS_OFF_INDIRECT_PORT_B 8'h01
`define CMMS_OFF_INDIRECT_POINTER_A 8'h02
`define CMMS_OFF_INDIRECT_POINTER_B 8'h03
`define CMMS_OFF_ALU_RESET_STATUS 8'h04
`define CMMS_OFF_WORKING_ACCUMULATOR 8'h05
`define CMMS_OFF_INTERRUPT_PENDING_FLAGS 8'h06
`define CMMS_OFF_INTERRUPT_ENABLE_MASK 8'h07

// Status field positions
`define CMMS_ST_POWER_DOWN 4
`define CMMS_ST_TIMEOUT 3
`define CMMS_ST_DIGIT_CARRY 2
`define CMMS_ST_CARRY 1
`define CMMS_ST_ZERO 0

// Implemented bit masks and reset values
`define CMMS_INTERRUPT_PENDING_FLAGS_MASK 8'h1f
`define CMMS_INTE_MASK 8'h9f
`define CMMS_INTERRUPT_PENDING_FLAGS_RESET 8'h00
`define CMMS_INTE_RESET 8'h00
`define CMMS_PTR_RESET 8'h00
`define CMMS_WORK_RESET 8'h00

// Flag operation codes
`define CMMS_FOP_NONE 2'h0
`define CMMS_FOP_ADD 2'h1
`define CMMS_FOP_SUB 2'h2
`define CMMS_FOP_LOGIC 2'h3

`endif

// [logic/cmms_core.v]
// Program counter, return stack, data map, pointers and status register
`include "cmms_defines.vh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Eleven-bit program counter over 2048 words
// - Six-entry return stack of 11-bit addresses
// - Any reset loads program counter with zero
// - Interrupt entry loads shared vector 0004h
// - Data space is 256 bytes, 8-bit address
// - 00h-07h decode to core system registers
// - 08h-7Fh routed to peripheral registers
// - 80h-FFh decode to general data memory
// - Indirect ports redirect through their pointer
// - Indirect read returns pointed memory location
// - Indirect write stores to pointed location
// - ALU flag results override status writes
// - Power-down set by sleep, write-proof
// - Timeout set by watchdog, cleared writing zero
// - Digit carry from low nibble, inverted subtract
// - Carry from top bit, inverted subtract
// - Zero flag when result equals zero
// - External reset clears; watchdog only sets timeout
module cmms_core #(
    parameter PC_W = `CMMS_PC_W,
    parameter STACK_DEPTH = `CMMS_STACK_DEPTH,
    parameter GP_WORDS = `CMMS_GP_WORDS
) (
    // Clock and resets
    input wire core_clk_i,
    input wire reset_i,
    input wire wdt_reset_i,
    // Program flow
    input wire pc_inc_i,
    input wire pc_load_i,
    input wire [PC_W-1:0] pc_target_i,
    input wire call_i,
    input wire ret_i,
    input wire irq_enter_i,
    input wire sleep_i,
    // Data read port
    input wire rd_en_i,
    input wire [7:0] rd_addr_i,
    input wire [7:0] periph_rdata_i,
    // Data write port
    input wire wr_en_i,
    input wire [7:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    // ALU flag results
    input wire [1:0] flag_op_i,
    input wire [7:0] alu_a_i,
    input wire [7:0] alu_b_i,
    input wire [7:0] alu_res_i,
    // Interrupt sources
    input wire [4:0] int_event_i,
    // Program side outputs
    output reg [PC_W-1:0] pc_o,
    // Data side outputs
    output reg [7:0] rd_data_o,
    output reg periph_wr_o,
    output reg [7:0] periph_addr_o,
    output reg [7:0] periph_wdata_o,
    // Core register views
    output reg [7:0] status_o,
    output reg [7:0] work_o,
    output reg [7:0] interrupt_pending_flags_o,
    output reg [7:0] inte_o
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    reg [PC_W-1:0] pc_q;
    reg [PC_W-1:0] pc_d;
    reg [PC_W-1:0] stack_q [0:STACK_DEPTH-1];
    reg [2:0] sp_q;
    reg [2:0] sp_d;
    reg [7:0] mem_q [0:GP_WORDS-1];
    reg [7:0] ptr_a_q;
    reg [7:0] ptr_b_q;
    reg [7:0] work_q;
    reg [7:0] interrupt_pending_flags_q;
    reg [7:0] inte_q;
    reg pd_q;
    reg to_q;
    reg dc_q;
    reg c_q;
    reg z_q;

    ////////////////////////////////////////////////////////////////////////
    // Address resolution
    // Indirect port maps to its pointer; a pointer aimed back at a port
    // resolves to the port itself, which reads zero and drops writes
    function [7:0] resolve;
        input [7:0] addr;
        input [7:0] pa;
        input [7:0] pb;
        begin
            if (addr == `CMMS_OFF_INDIRECT_PORT_A) begin
                resolve = pa;
            end else if (addr == `CMMS_OFF_INDIRECT_PORT_B) begin
                resolve = pb;
            end else begin
                resolve = addr;
            end
        end
    endfunction

    function is_port;
        input [7:0] addr;
        begin
            is_port = (addr == `CMMS_OFF_INDIRECT_PORT_A) ||
                      (addr == `CMMS_OFF_INDIRECT_PORT_B);
        end
    endfunction

    wire [7:0] rd_eff = resolve(rd_addr_i, ptr_a_q, ptr_b_q);
    wire [7:0] wr_eff = resolve(wr_addr_i, ptr_a_q, ptr_b_q);
    wire wr_ok = wr_en_i && !is_port(wr_eff);
    wire wr_sys = wr_ok && (wr_eff <= `CMMS_SYS_LAST);
    wire wr_gp = wr_ok && (wr_eff >= `CMMS_GP_FIRST);
    wire wr_per = wr_ok && !wr_sys && !wr_gp;

    ////////////////////////////////////////////////////////////////////////
    // Flag computation
    wire [8:0] add_sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};
    wire [4:0] add_nib = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
    wire [7:0] sub_res = alu_a_i - alu_b_i;
    wire is_add = (flag_op_i == `CMMS_FOP_ADD);
    wire is_sub = (flag_op_i == `CMMS_FOP_SUB);
    wire is_arith = is_add || is_sub;
    wire upd_z = (flag_op_i != `CMMS_FOP_NONE);
    // Subtract reports not-borrow, so a >= b reads as carry set
    wire dc_new = is_add ? add_nib[4] :
                  (alu_a_i[3:0] >= alu_b_i[3:0]);
    wire c_new = is_add ? add_sum[8] : (alu_a_i >= alu_b_i);
    wire [7:0] z_src = is_add ? add_sum[7:0] :
                       (is_sub ? sub_res : alu_res_i);
    wire z_new = (z_src == 8'h00);

    wire st_wr = wr_sys && (wr_eff == `CMMS_OFF_ALU_RESET_STATUS);
    wire [7:0] status_now = {3'b000, pd_q, to_q, dc_q, c_q, z_q};

    ////////////////////////////////////////////////////////////////////////
    // Read decode
    function [7:0] sys_read;
        input [2:0] idx;
        input [7:0] pa;
        input [7:0] pb;
        input [7:0] st;
        input [7:0] wk;
        input [7:0] fl;
        input [7:0] en;
        begin
            case (idx)
                3'h2: sys_read = pa;
                3'h3: sys_read = pb;
                3'h4: sys_read = st;
                3'h5: sys_read = wk;
                3'h6: sys_read = fl & `CMMS_INTERRUPT_PENDING_FLAGS_MASK;
                3'h7: sys_read = en & `CMMS_INTE_MASK;
                default: sys_read = 8'h00;
            endcase
        end
    endfunction

    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        if (rd_eff <= `CMMS_SYS_LAST) begin
            rd_d = sys_read(rd_eff[2:0], ptr_a_q, ptr_b_q, status_now,
                            work_q, interrupt_pending_flags_q, inte_q);
        end else if (rd_eff >= `CMMS_GP_FIRST) begin
            rd_d = mem_q[rd_eff[6:0]];
        end else begin
            rd_d = periph_rdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter and stack pointer
    wire [31:0] sp_last = STACK_DEPTH - 1;
    wire [2:0] sp_inc = (sp_q == sp_last[2:0]) ? 3'h0 : sp_q + 3'h1;
    wire [2:0] sp_dec = (sp_q == 3'h0) ? sp_last[2:0] : sp_q - 3'h1;
    wire push = irq_enter_i || call_i;
    wire [PC_W-1:0] push_val = irq_enter_i ? pc_q : pc_q + 1'b1;

    always @* begin
        pc_d = pc_q;
        sp_d = sp_q;
        if (wdt_reset_i) begin
            pc_d = `CMMS_RESET_VEC;
        end else if (irq_enter_i) begin
            pc_d = `CMMS_INT_VEC;
            sp_d = sp_inc;
        end else if (call_i) begin
            pc_d = pc_target_i;
            sp_d = sp_inc;
        end else if (ret_i) begin
            pc_d = stack_q[sp_dec];
            sp_d = sp_dec;
        end else if (pc_load_i) begin
            pc_d = pc_target_i;
        end else if (pc_inc_i) begin
            pc_d = pc_q + 1'b1;
        end
    end

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_q <= `CMMS_RESET_VEC;
            sp_q <= 3'h0;
        end else begin
            pc_q <= pc_d;
            sp_q <= sp_d;
        end
    end

    // Oldest entry is overwritten once the ring wraps
    always @(posedge core_clk_i) begin
        if (!wdt_reset_i && push) begin
            stack_q[sp_q] <= push_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // General data memory, not reset
    always @(posedge core_clk_i) begin
        if (wr_gp && !wdt_reset_i) begin
            mem_q[wr_eff[6:0]] <= wr_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System registers
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ptr_a_q <= `CMMS_PTR_RESET;
            ptr_b_q <= `CMMS_PTR_RESET;
            work_q <= `CMMS_WORK_RESET;
            interrupt_pending_flags_q <= `CMMS_INTERRUPT_PENDING_FLAGS_RESET;
            inte_q <= `CMMS_INTE_RESET;
            pd_q <= 1'b0;
            to_q <= 1'b0;
            dc_q <= 1'b0;
            c_q <= 1'b0;
            z_q <= 1'b0;
        end else if (wdt_reset_i) begin
            to_q <= 1'b1;
        end else begin
            if (wr_sys && wr_eff == `CMMS_OFF_INDIRECT_POINTER_A) begin
                ptr_a_q <= wr_data_i;
            end
            if (wr_sys && wr_eff == `CMMS_OFF_INDIRECT_POINTER_B) begin
                ptr_b_q <= wr_data_i;
            end
            if (wr_sys && wr_eff == `CMMS_OFF_WORKING_ACCUMULATOR) begin
                work_q <= wr_data_i;
            end
            if (wr_sys && wr_eff == `CMMS_OFF_INTERRUPT_ENABLE_MASK) begin
                inte_q <= wr_data_i & `CMMS_INTE_MASK;
            end
            // A source event wins over a clearing write in the same cycle
            if (wr_sys && wr_eff == `CMMS_OFF_INTERRUPT_PENDING_FLAGS) begin
                interrupt_pending_flags_q <= (wr_data_i | {3'b000, int_event_i}) &
                          `CMMS_INTERRUPT_PENDING_FLAGS_MASK;
            end else begin
                interrupt_pending_flags_q <= interrupt_pending_flags_q | {3'b000, int_event_i};
            end
            if (sleep_i) begin
                pd_q <= 1'b1;
            end
            if (st_wr && !wr_data_i[`CMMS_ST_TIMEOUT]) begin
                to_q <= 1'b0;
            end
            // Flag results take precedence over a write to the same bits
            if (is_arith) begin
                dc_q <= dc_new;
                c_q <= c_new;
            end else if (st_wr) begin
                dc_q <= wr_data_i[`CMMS_ST_DIGIT_CARRY];
                c_q <= wr_data_i[`CMMS_ST_CARRY];
            end
            if (upd_z) begin
                z_q <= z_new;
            end else if (st_wr) begin
                z_q <= wr_data_i[`CMMS_ST_ZERO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_o <= `CMMS_RESET_VEC;
            rd_data_o <= 8'h00;
            periph_wr_o <= 1'b0;
            periph_addr_o <= 8'h00;
            periph_wdata_o <= 8'h00;
            status_o <= 8'h00;
            work_o <= 8'h00;
            interrupt_pending_flags_o <= 8'h00;
            inte_o <= 8'h00;
        end else begin
            pc_o <= pc_d;
            if (rd_en_i) begin
                rd_data_o <= rd_d;
            end
            periph_wr_o <= wr_per && !wdt_reset_i;
            if (wr_per) begin
                periph_addr_o <= wr_eff;
                periph_wdata_o <= wr_data_i;
            end
            status_o <= status_now;
            work_o <= work_q;
            interrupt_pending_flags_o <= interrupt_pending_flags_q & `CMMS_INTERRUPT_PENDING_FLAGS_MASK;
            inte_o <= inte_q & `CMMS_INTE_MASK;
        end
    end

endmodule // cmms_core

// [sim/cmms_periph_model.sv]
// Peripheral register stand-in that answers reads on the data map
module cmms_periph_model (
    input logic [7:0] rd_addr_i,
    output logic [7:0] periph_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Address-dependent pattern, so a stale or misrouted read shows up
    assign periph_rdata_i = rd_addr_i ^ 8'h5a;
endmodule // cmms_periph_model

// [sim/cmms_core_monitor.sv]
// Port-level assertions for the memory map and status block
module cmms_core_monitor #(parameter PC_W = 11) (
    input logic core_clk_i, reset_i, wdt_reset_i, pc_inc_i, pc_load_i,
    input logic call_i, ret_i, irq_enter_i, sleep_i, wr_en_i, periph_wr_o,
    input logic [PC_W-1:0] pc_target_i, pc_o,
    input logic [7:0] wr_addr_i, wr_data_i, periph_addr_o, periph_wdata_o,
    input logic [7:0] status_o, interrupt_pending_flags_o, inte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////////
    sequence s_pwr_req;
        wr_en_i && !wdt_reset_i && wr_addr_i >= 8'h08 && wr_addr_i <= 8'h7f;
    endsequence
    // Pulse must drop unless another write follows at once
    sequence s_pwr_out;
        periph_wr_o && periph_addr_o == $past(wr_addr_i) &&
        periph_wdata_o == $past(wr_data_i) ##1
        (!periph_wr_o || $past(wr_en_i));
    endsequence
    ////////////////////////////////////////////////////////////////////
    wdt_vector_a: assert property (wdt_reset_i |=> pc_o == 0)
        else $error("pc not zero after watchdog reset");
    irq_vector_a: assert property (irq_enter_i && !wdt_reset_i
        |=> pc_o == 11'h004) else $error("pc not at interrupt vector");
    call_target_a: assert property (call_i && !wdt_reset_i &&
        !irq_enter_i |=> pc_o == $past(pc_target_i))
        else $error("call did not reach target");
    pc_step_a: assert property (pc_inc_i && !(wdt_reset_i ||
        irq_enter_i || call_i || ret_i || pc_load_i)
        |=> pc_o == $past(pc_o) + 1'b1) else $error("pc step wrong");
    periph_wr_a: assert property (s_pwr_req |=> s_pwr_out)
        else $error("peripheral write not forwarded");
    gp_no_periph_a: assert property (wr_en_i && wr_addr_i[7]
        |=> !periph_wr_o) else $error("memory write leaked out");
    pd_cause_a: assert property ($changed(status_o[4])
        |-> status_o[4] && $past(sleep_i, 2))
        else $error("power down flag changed without sleep");
    to_cause_a: assert property ($rose(status_o[3])
        |-> $past(wdt_reset_i, 2)) else $error("timeout flag set wrongly");
    unimpl_zero_a: assert property (status_o[7:5] == 3'h0 &&
        interrupt_pending_flags_o[7:5] == 3'h0 && inte_o[6:5] == 2'h0)
        else $error("unimplemented bit set");
endmodule // cmms_core_monitor

bind cmms_core cmms_core_monitor #(.PC_W(PC_W)) cmms_core_monitor_i (
    .core_clk_i, .reset_i, .wdt_reset_i, .pc_inc_i, .pc_load_i, .call_i,
    .ret_i, .irq_enter_i, .sleep_i, .wr_en_i, .periph_wr_o, .pc_target_i,
    .pc_o, .wr_addr_i, .wr_data_i, .periph_addr_o, .periph_wdata_o,
    .status_o, .interrupt_pending_flags_o, .inte_o);

// [sim/cmms_core_tb_top.sv]
// Self-checking bench for the memory map and status block
module cmms_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 0, reset_i = 1, wdt_reset_i = 0, pc_inc_i = 0;
    logic pc_load_i = 0, call_i = 0, ret_i = 0, irq_enter_i = 0, sleep_i = 0;
    logic rd_en_i = 0, wr_en_i = 0, pc_check = 0, vw_check = 0;
    logic [10:0] pc_target_i = 11'h000;
    logic [7:0] rd_addr_i = 0, wr_addr_i = 0, wr_data_i = 0, d;
    logic [7:0] alu_a_i = 0, alu_b_i = 0;
    logic [1:0] flag_op_i = 2'h0;
    logic [4:0] st = 5'h00;
    logic [4:0] int_event_i = 5'h00;
    wire [7:0] periph_rdata_i, rd_data_o, periph_addr_o, periph_wdata_o;
    wire [7:0] status_o, work_o, interrupt_pending_flags_o, inte_o;
    wire [10:0] pc_o;
    wire periph_wr_o;
    logic [7:0] qd[$];
    logic [10:0] qp[$];
    logic [15:0] qw[$];
    logic [7:0] qv[$];
    string qn[$];
    string vn;
    int mismatches = 0, n_compared = 0, cycles = 0, i;
    ////////////////////////////////////////////////////////////////////
    cmms_core cmms_core_i (.core_clk_i, .reset_i, .wdt_reset_i, .pc_inc_i,
        .pc_load_i, .pc_target_i, .call_i, .ret_i, .irq_enter_i, .sleep_i,
        .rd_en_i, .rd_addr_i, .periph_rdata_i, .wr_en_i, .wr_addr_i,
        .wr_data_i, .flag_op_i, .alu_a_i, .alu_b_i,
        .alu_res_i(alu_a_i & alu_b_i), .int_event_i, .pc_o,
        .rd_data_o, .periph_wr_o, .periph_addr_o, .periph_wdata_o,
        .status_o, .work_o, .interrupt_pending_flags_o, .inte_o);
    cmms_periph_model cmms_periph_model_i (.rd_addr_i, .periph_rdata_i);
    always #2.5 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////
    task chk(input string n, input [15:0] e, s);
        n_compared++;
        if (e !== s) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task conclude;
        if (qd.size() + qp.size() + qw.size() + qv.size() != 0) begin
            mismatches++;
            $display("unexpected queue_leftover expected 0 seen %0d",
                qd.size() + qp.size() + qw.size() + qv.size());
        end
        $display("counts: %0d compared, %0d mismatches", n_compared,
            mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Control bits: wdt, sleep, irq, ret, call, load, inc
    task drv(input [6:0] c, input w, input [7:0] a, v, input [1:0] o,
        input [7:0] p, r);
        @(negedge core_clk_i);
        {wdt_reset_i, sleep_i, irq_enter_i, ret_i, call_i, pc_load_i,
            pc_inc_i} = c;
        {wr_en_i, wr_addr_i, wr_data_i, flag_op_i, alu_a_i, alu_b_i} =
            {w, a, v, o, p, r};
        @(negedge core_clk_i);
        {wdt_reset_i, sleep_i, irq_enter_i, ret_i, call_i, pc_load_i,
            pc_inc_i, wr_en_i, flag_op_i} = 10'h000;
    endtask
    task wr(input [7:0] a, v); drv(0, 1, a, v, 0, 0, 0); endtask
    task rd(input [7:0] a, e);
        qd.push_back(e);
        @(negedge core_clk_i);
        {rd_en_i, rd_addr_i} = {1'b1, a};
        @(negedge core_clk_i);
        rd_en_i = 0;
    endtask
    task pc(input [10:0] e);
        qp.push_back(e);
        @(negedge core_clk_i);
        pc_check = 1;
        @(negedge core_clk_i);
        pc_check = 0;
    endtask
    // Registered views lag one cycle, so they are looked at an idle edge later
    task vw(input string n, input [7:0] e);
        qn.push_back(n);
        qv.push_back(e);
        @(negedge core_clk_i);
        vw_check = 1;
        @(negedge core_clk_i);
        vw_check = 0;
    endtask
    task fl(input [1:0] o, input [7:0] p, r);
        if (o == 1) st[2:0] = {p[3:0] + r[3:0] > 15, p + r > 255,
            p + r == 256 || p + r == 0};
        else if (o == 2) st[2:0] = {p[3:0] >= r[3:0], p >= r, p == r};
        else st[0] = (p & r) == 0;
        drv(0, 0, 0, 0, o, p, r);
        rd(8'h04, {3'h0, st});
    endtask
    ////////////////////////////////////////////////////////////////////
    // Watchers: compare each result with the oldest note
    always @(posedge core_clk_i)
        if (pc_check === 1'b1) chk("pc_o", qp.pop_front(), pc_o);
    always @(posedge core_clk_i)
        if (rd_en_i === 1'b1) begin
            #1;
            chk("rd_data_o", qd.pop_front(), rd_data_o);
        end
    always @(posedge core_clk_i)
        if (vw_check === 1'b1) begin
            vn = qn.pop_front();
            chk(vn, qv.pop_front(), vn == "status_o" ? status_o :
                vn == "work_o" ? work_o : vn == "interrupt_pending_flags_o" ? interrupt_pending_flags_o : inte_o);
        end
    // Pulse stands one cycle; an unexpected pulse pops an empty queue
    always @(posedge core_clk_i)
        if (periph_wr_o === 1'b1)
            chk("periph_addr_o,periph_wdata_o", qw.pop_front(),
                {periph_addr_o, periph_wdata_o});
    // Whole run is a few hundred cycles; generous ceiling
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            $display("unexpected cycles expected below %0d seen %0d", 3000,
                cycles);
            conclude;
        end
    end
    initial begin
        void'($urandom(32'he9ca));
        repeat (5) @(posedge core_clk_i);
        @(negedge core_clk_i) reset_i = 0;
        pc(11'h000);
        rd(8'h04, 8'h00);
        repeat (3) drv(1, 0, 0, 0, 0, 0, 0);
        pc(11'h003);
        pc_target_i = 11'h7ff;
        drv(2, 0, 0, 0, 0, 0, 0);
        drv(1, 0, 0, 0, 0, 0, 0);
        pc(11'h000);
        $display("test program counter done");
        // Seven calls into a six-deep ring drop the oldest return
        for (i = 0; i < 7; i++) begin
            pc_target_i = 11'h100 + 8 * i;
            drv(4, 0, 0, 0, 0, 0, 0);
        end
        pc(11'h130);
        for (i = 5; i >= 0; i--) begin
            drv(8, 0, 0, 0, 0, 0, 0);
            pc(11'h101 + 8 * i);
        end
        drv(16, 0, 0, 0, 0, 0, 0);
        pc(11'h004);
        drv(8, 0, 0, 0, 0, 0, 0);
        pc(11'h101);
        $display("test return stack done");
        d = $urandom;
        wr(8'h02, 8'h90);
        wr(8'h00, d);
        rd(8'h90, d);
        rd(8'h00, d);
        wr(8'h85, ~d);
        wr(8'h03, 8'h85);
        rd(8'h01, ~d);
        wr(8'hff, 8'h3c);
        rd(8'hff, 8'h3c);
        rd(8'h20, 8'h7a);
        qw.push_back({8'h20, d});
        wr(8'h20, d);
        wr(8'h03, 8'h30);
        qw.push_back({8'h30, ~d});
        wr(8'h01, ~d);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h1f);
        // Source event during the clearing write must survive it
        int_event_i = 5'h04;
        wr(8'h06, 8'h00);
        int_event_i = 5'h00;
        rd(8'h06, 8'h04);
        vw("interrupt_pending_flags_o", 8'h04);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h9f);
        vw("inte_o", 8'h9f);
        wr(8'h05, 8'h77);
        rd(8'h05, 8'h77);
        vw("work_o", 8'h77);
        $display("test data map done");
        wr(8'h04, 8'hff);
        st = 5'h07;
        rd(8'h04, 8'h07);
        fl(1, 8'hff, 8'h01);
        fl(2, 8'h10, 8'h01);
        fl(3, 8'h0f, 8'hf0);
        repeat (10) fl(1 + $urandom % 3, $urandom, $urandom);
        drv(0, 1, 8'h04, 8'hff, 1, 8'h00, 8'h00);
        st[2:0] = 3'h1;
        rd(8'h04, {3'h0, st});
        drv(32, 0, 0, 0, 0, 0, 0);
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h10);
        vw("status_o", 8'h10);
        drv(64, 0, 0, 0, 0, 0, 0);
        pc(11'h000);
        rd(8'h04, 8'h18);
        vw("status_o", 8'h18);
        rd(8'h02, 8'h90);
        rd(8'h05, 8'h77);
        wr(8'h04, 8'h08);
        rd(8'h04, 8'h18);
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h10);
        $display("test status done");
        // External reset in mid-run clears flags, pointers and the counter
        drv(1, 0, 0, 0, 0, 0, 0);
        @(negedge core_clk_i) reset_i = 1;
        @(negedge core_clk_i) reset_i = 0;
        pc(11'h000);
        rd(8'h04, 8'h00);
        rd(8'h02, 8'h00);
        vw("status_o", 8'h00);
        $display("test second reset done");
        repeat (3) @(negedge core_clk_i);
        conclude;
    end
endmodule // cmms_core_tb_top
